//--- tgp_i2c_slave.sv
`timescale 1ns/10ps
module tgp_i2c_slave
  import tgp_pkg::*;
(
  input  wire logic           clock,
  input  wire logic           sys_rst,
  input  wire logic           scl_in,
  input  wire logic           sda_in,
  input  wire logic [6:0]     slave_addr,
  output logic                sda_oe,
  tgp_regbus_if.slave_side    bus
);

  // --------------------------------------------------------------------------
  // pin synchronisers
  // --------------------------------------------------------------------------
  logic       scl_s1_q, scl_s2_q, scl_d1_q;
  logic       sda_s1_q, sda_s2_q, sda_d1_q;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_d1_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_d1_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_d1_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_d1_q <= sda_s2_q;
    end
  end

  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise  = scl_s2_q & ~scl_d1_q;
  assign scl_fall  = ~scl_s2_q & scl_d1_q;
  assign start_det = scl_s2_q & scl_d1_q & sda_d1_q & ~sda_s2_q;
  assign stop_det  = scl_s2_q & scl_d1_q & ~sda_d1_q & sda_s2_q;

  // --------------------------------------------------------------------------
  // transfer framing
  // --------------------------------------------------------------------------
  tgp_state_e state_q;
  logic [7:0] shift_q, tx_q, ptr_q;
  logic [3:0] bitcnt_q;
  logic       rw_q, nack_q, wr_stb_q, rd_stb_q;

  assign bus.wr_stb = wr_stb_q;
  assign bus.rd_stb = rd_stb_q;
  assign bus.addr   = ptr_q;
  assign bus.wdata  = shift_q;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_q  <= TGP_IDLE;
      shift_q  <= 8'h00;
      tx_q     <= 8'h00;
      ptr_q    <= 8'h00;
      bitcnt_q <= 4'h0;
      rw_q     <= 1'b0;
      nack_q   <= 1'b0;
      sda_oe   <= 1'b0;
      wr_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
    end else begin
      wr_stb_q <= 1'b0;
      rd_stb_q <= 1'b0;
      if (start_det) begin
        state_q  <= TGP_ADDR;
        bitcnt_q <= 4'h0;
        sda_oe   <= 1'b0;
      end else if (stop_det) begin
        state_q <= TGP_IDLE;
        sda_oe  <= 1'b0;
      end else if (scl_rise && state_q != TGP_IDLE) begin
        shift_q  <= {shift_q[6:0], sda_s2_q};
        bitcnt_q <= bitcnt_q + 4'h1;
        if (state_q == TGP_RDATA_ACK) nack_q <= sda_s2_q;
      end else if (scl_fall) begin
        case (state_q)
          TGP_ADDR: begin
            if (bitcnt_q == BITS_PER_BYTE) begin
              if (shift_q[7:1] == slave_addr) begin
                rw_q    <= shift_q[0];
                sda_oe  <= 1'b1;
                state_q <= TGP_ADDR_ACK;
              end else begin
                state_q <= TGP_IDLE;
              end
            end
          end
          TGP_ADDR_ACK: begin
            bitcnt_q <= 4'h0;
            if (rw_q) begin
              rd_stb_q <= 1'b1;
              tx_q     <= bus.rdata;
              sda_oe   <= ~bus.rdata[7];
              ptr_q    <= ptr_q + 8'h01;
              state_q  <= TGP_RDATA;
            end else begin
              sda_oe  <= 1'b0;
              state_q <= TGP_REG;
            end
          end
          TGP_REG: begin
            if (bitcnt_q == BITS_PER_BYTE) begin
              ptr_q   <= shift_q;
              sda_oe  <= 1'b1;
              state_q <= TGP_REG_ACK;
            end
          end
          TGP_WDATA: begin
            if (bitcnt_q == BITS_PER_BYTE) begin
              wr_stb_q <= 1'b1;
              sda_oe   <= 1'b1;
              state_q  <= TGP_WDATA_ACK;
            end
          end
          TGP_REG_ACK, TGP_WDATA_ACK: begin
            if (state_q == TGP_WDATA_ACK) ptr_q <= ptr_q + 8'h01;
            sda_oe   <= 1'b0;
            bitcnt_q <= 4'h0;
            state_q  <= TGP_WDATA;
          end
          TGP_RDATA: begin
            if (bitcnt_q == BITS_PER_BYTE) begin
              sda_oe   <= 1'b0;
              bitcnt_q <= 4'h0;
              state_q  <= TGP_RDATA_ACK;
            end else begin
              tx_q   <= {tx_q[6:0], 1'b0};
              sda_oe <= ~tx_q[6];
            end
          end
          TGP_RDATA_ACK: begin
            bitcnt_q <= 4'h0;
            if (nack_q) begin
              state_q <= TGP_IDLE;
            end else begin
              rd_stb_q <= 1'b1;
              tx_q     <= bus.rdata;
              sda_oe   <= ~bus.rdata[7];
              ptr_q    <= ptr_q + 8'h01;
              state_q  <= TGP_RDATA;
            end
          end
          default: ;
        endcase
      end
    end
  end

endmodule : tgp_i2c_slave

//--- tgp_master_model.sv
`timescale 1ns/10ps
module tgp_master_model
  import tgp_pkg::*;
#(
  parameter logic [6:0] SLAVE = SLAVE_ADDR_GND
) (
  input wire logic clock,
  input wire logic sda_line,
  output logic     scl,
  output logic     sda_low
);
  logic [6:0] target_addr = SLAVE;
  // --------
  // bit and byte framing, clock stands high when idle
  // --------
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic hp();
    repeat (16) @(negedge clock);
  endtask : hp
  task automatic pulse();
    hp();
    scl = 1'b1;
    hp();
  endtask : pulse
  task automatic start();
    sda_low = 1'b0;
    pulse();
    sda_low = 1'b1;
    hp();
    scl = 1'b0;
  endtask : start
  task automatic stop();
    sda_low = 1'b1;
    pulse();
    sda_low = 1'b0;
    hp();
  endtask : stop
  task automatic tx(input logic [7:0] b, inout logic ok);
    for (int i = 7; i >= 0; i--) begin
      sda_low = !b[i];
      pulse();
      scl = 1'b0;
    end
    sda_low = 1'b0;
    pulse();
    ok = ok & !sda_line;
    scl = 1'b0;
  endtask : tx
  task automatic wr(input logic [7:0] r, input logic [39:0] d, input int n, output logic ok);
    ok = 1'b1;
    start();
    tx({target_addr, 1'b0}, ok);
    tx(r, ok);
    for (int k = n - 1; k >= 0; k--)
      tx(d[8*k+:8], ok);
    stop();
  endtask : wr
  task automatic rd(input logic [7:0] r, output logic [7:0] v, output logic ok);
    ok = 1'b1;
    start();
    tx({target_addr, 1'b0}, ok);
    tx(r, ok);
    start();
    tx({target_addr, 1'b1}, ok);
    for (int i = 7; i >= 0; i--) begin
      pulse();
      v[i] = sda_line;
      scl = 1'b0;
    end
    pulse();
    scl = 1'b0;
    stop();
  endtask : rd
endmodule : tgp_master_model

//--- tgp_pkg.sv
package tgp_pkg;

  // --------------------------------------------------------------------------
  // widths
  // --------------------------------------------------------------------------
  localparam int NUM_PORTS  = 8;
  localparam int NUM_CHANS  = 13;
  localparam int DATA_W     = 10;
  localparam int LIMIT_W    = 8;
  localparam int LIMIT_SHIFT = 2;

  // --------------------------------------------------------------------------
  // register offsets
  // --------------------------------------------------------------------------
  localparam logic [7:0] REG_RANGE_FAULT_LOW  = 8'h02;
  localparam logic [7:0] REG_RANGE_FAULT_HIGH = 8'h03;
  localparam logic [7:0] REG_PORT_CONFIG_A    = 8'h73;
  localparam logic [7:0] REG_PORT_CONFIG_B    = 8'h74;
  localparam logic [7:0] REG_PORT_LEVEL_DATA  = 8'h75;
  localparam logic [7:0] REG_PORT_DIRECTION   = 8'h76;
  localparam logic [7:0] REG_PORT_ENABLE      = 8'h77;
  localparam logic [7:0] REG_PORT_LEVEL_SET   = 8'h78;
  localparam logic [7:0] REG_PORT_LEVEL_CLEAR = 8'h79;
  localparam logic [7:0] REG_PORT_LEVEL_TOG   = 8'h7A;
  localparam logic [7:0] REG_SOFT_RESET       = 8'h80;

  // --------------------------------------------------------------------------
  // values and field positions
  // --------------------------------------------------------------------------
  localparam logic [7:0] SOFT_RESET_KEY     = 8'h63;
  localparam logic [7:0] REG_RESET_VAL      = 8'h00;
  localparam logic [7:0] READ_ZERO          = 8'h00;
  localparam int         AUTOCFG_FAIL_BIT   = 7;
  localparam int         RECFG_FAIL_BIT     = 6;
  localparam int         LOW_STATUS_CHANS   = 8;

  // port configuration pair {first, second}
  localparam logic [1:0] CFG_PLAIN     = 2'b00;
  localparam logic [1:0] CFG_HIGH_SIDE = 2'b11;
  localparam logic [1:0] CFG_LOW_SIDE  = 2'b10;
  localparam logic [1:0] CFG_PULL_UP   = 2'b11;
  localparam logic [1:0] CFG_PULL_DOWN = 2'b10;

  // serial slave addresses by strap connection
  localparam logic [6:0] SLAVE_ADDR_GND = 7'h5A;
  localparam logic [6:0] SLAVE_ADDR_VDD = 7'h5B;
  localparam logic [6:0] SLAVE_ADDR_SDA = 7'h5C;
  localparam logic [6:0] SLAVE_ADDR_SCL = 7'h5D;
  localparam logic [1:0] STRAP_GND = 2'b00;
  localparam logic [1:0] STRAP_VDD = 2'b01;
  localparam logic [1:0] STRAP_SDA = 2'b10;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  typedef enum logic [3:0] {
    TGP_IDLE, TGP_ADDR, TGP_ADDR_ACK, TGP_REG, TGP_REG_ACK,
    TGP_WDATA, TGP_WDATA_ACK, TGP_RDATA, TGP_RDATA_ACK
  } tgp_state_e;

endpackage : tgp_pkg

//--- tgp_port_top.sv
`timescale 1ns/10ps
// What this block does
// - channel range fault bits follow check, read-only
// - fail flags at upper status bits 7,6
// - compare data against limits after checks
// - key 0x63 at 0x80 resets all but serial
// - register bits 7..0 map pins 11..4
// - port registers writable in any mode
// - electrode selection overrides port enable one clock later
// - after reset all ports disabled, high impedance
// - enable zero means pin high impedance
// - input types: plain, pull-down, pull-up
// - output types: push-pull, high-side, low-side
// - output pin drives its data bit
// - level change waits from charging start until conversion done
// - output port reads stored data bit
// - input port reads latched pin level
// - data writes stored, input unaffected
// - set, clear, toggle by writing ones
// - set, clear, toggle read data register
// - slave only, clock from master is input
// - data line open drain, never driven high
// - start, address, register, data, stop framing
// - slave address from strap connection
module tgp_port_top
  import tgp_pkg::*;
#(
  parameter int PORTS = NUM_PORTS,
  parameter int CHANS = NUM_CHANS
) (
  input  wire logic                    clock,
  input  wire logic                    sys_rst,
  input  wire logic                    scl_in,
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe,
  input  wire logic [1:0]              addr_strap,
  input  wire logic [PORTS-1:0]        electrode_mask,
  input  wire logic                    run_mode,
  input  wire logic                    charging,
  input  wire logic                    conv_done,
  input  wire logic                    check_stb,
  input  wire logic                    check_reconfig,
  input  wire logic                    autocfg_en,
  input  wire logic [LIMIT_W-1:0]      upper_data_limit,
  input  wire logic [LIMIT_W-1:0]      lower_data_limit,
  input  wire logic [CHANS*DATA_W-1:0] chan_data,
  input  wire logic [PORTS-1:0]        port_in,
  output logic      [PORTS-1:0]        port_out,
  output logic      [PORTS-1:0]        port_oe,
  output logic      [PORTS-1:0]        port_pull_up,
  output logic      [PORTS-1:0]        port_pull_down,
  output logic                         soft_reset_out
);

  tgp_regbus_if bus ();

  // --------------------------------------------------------------------------
  // address strap, caught after reset release
  // --------------------------------------------------------------------------
  logic [1:0] strap_s1_q, strap_s2_q;
  logic [6:0] slave_addr_q;
  logic       strap_done_q;
  always_ff @(posedge clock) begin
    strap_s1_q <= addr_strap;
    strap_s2_q <= strap_s1_q;
  end
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      strap_done_q <= 1'b0;
      slave_addr_q <= SLAVE_ADDR_GND;
    end else if (!strap_done_q) begin
      strap_done_q <= 1'b1;
      if (strap_s2_q == STRAP_GND)      slave_addr_q <= SLAVE_ADDR_GND;
      else if (strap_s2_q == STRAP_VDD) slave_addr_q <= SLAVE_ADDR_VDD;
      else if (strap_s2_q == STRAP_SDA) slave_addr_q <= SLAVE_ADDR_SDA;
      else                              slave_addr_q <= SLAVE_ADDR_SCL;
    end
  end

  // --------------------------------------------------------------------------
  // serial slave, untouched by soft reset
  // --------------------------------------------------------------------------
  tgp_i2c_slave u_slave (
    .clock      (clock),
    .sys_rst    (sys_rst),
    .scl_in     (scl_in),
    .sda_in     (sda_in),
    .slave_addr (slave_addr_q),
    .sda_oe     (sda_oe),
    .bus        (bus.slave_side)
  );

  always_ff @(posedge clock) begin
    sda_out <= 1'b0;
  end

  // --------------------------------------------------------------------------
  // soft reset
  // --------------------------------------------------------------------------
  logic soft_rst_q, blk_rst;
  assign blk_rst = sys_rst | soft_rst_q;
  always_ff @(posedge clock) begin
    if (sys_rst) soft_rst_q <= 1'b0;
    else soft_rst_q <= bus.wr_stb && bus.addr == REG_SOFT_RESET
                       && bus.wdata == SOFT_RESET_KEY;
  end
  always_ff @(posedge clock) begin
    if (sys_rst) soft_reset_out <= 1'b0;
    else soft_reset_out <= soft_rst_q;
  end

  // --------------------------------------------------------------------------
  // port registers
  // --------------------------------------------------------------------------
  logic [PORTS-1:0] cfg_a_q, cfg_b_q, data_q, dir_q, en_q;
  logic             wr;
  assign wr = bus.wr_stb;

  always_ff @(posedge clock) begin
    if (blk_rst) begin
      cfg_a_q <= PORTS'(REG_RESET_VAL);
      cfg_b_q <= PORTS'(REG_RESET_VAL);
      dir_q   <= PORTS'(REG_RESET_VAL);
      en_q    <= PORTS'(REG_RESET_VAL);
    end else if (wr) begin
      if (bus.addr == REG_PORT_CONFIG_A)      cfg_a_q <= bus.wdata[PORTS-1:0];
      else if (bus.addr == REG_PORT_CONFIG_B) cfg_b_q <= bus.wdata[PORTS-1:0];
      else if (bus.addr == REG_PORT_DIRECTION) dir_q  <= bus.wdata[PORTS-1:0];
      else if (bus.addr == REG_PORT_ENABLE)   en_q    <= bus.wdata[PORTS-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (blk_rst) begin
      data_q <= PORTS'(REG_RESET_VAL);
    end else if (wr) begin
      if (bus.addr == REG_PORT_LEVEL_DATA)       data_q <= bus.wdata[PORTS-1:0];
      else if (bus.addr == REG_PORT_LEVEL_SET)   data_q <= data_q | bus.wdata[PORTS-1:0];
      else if (bus.addr == REG_PORT_LEVEL_CLEAR) data_q <= data_q & ~bus.wdata[PORTS-1:0];
      else if (bus.addr == REG_PORT_LEVEL_TOG)   data_q <= data_q ^ bus.wdata[PORTS-1:0];
    end
  end

  // --------------------------------------------------------------------------
  // pin input synchronise and latch
  // --------------------------------------------------------------------------
  logic [PORTS-1:0] in_s1_q, in_s2_q, in_lat_q;
  always_ff @(posedge clock) begin
    if (blk_rst) begin
      in_s1_q  <= '0;
      in_s2_q  <= '0;
      in_lat_q <= '0;
    end else begin
      in_s1_q  <= port_in;
      in_s2_q  <= in_s1_q;
      in_lat_q <= in_s2_q;
    end
  end

  // --------------------------------------------------------------------------
  // applied output level, held while charging
  // --------------------------------------------------------------------------
  logic [PORTS-1:0] level_q;
  logic             charge_seen_q;
  always_ff @(posedge clock) begin
    if (blk_rst) begin
      level_q       <= '0;
      charge_seen_q <= 1'b0;
    end else begin
      if (conv_done) charge_seen_q <= 1'b0;
      if (charging) charge_seen_q <= 1'b1;
      if (!charging && (!charge_seen_q || conv_done)) level_q <= data_q;
    end
  end

  // --------------------------------------------------------------------------
  // pin drivers, bit i steers sense pin i+4
  // --------------------------------------------------------------------------
  logic [PORTS-1:0] active;
  assign active = en_q & ~electrode_mask;

  genvar gi;
  generate
    for (gi = 0; gi < PORTS; gi++) begin : g_pin
      logic [1:0] cfg;
      assign cfg = {cfg_a_q[gi], cfg_b_q[gi]};
      always_ff @(posedge clock) begin
        if (blk_rst) begin
          port_out[gi]       <= 1'b0;
          port_oe[gi]        <= 1'b0;
          port_pull_up[gi]   <= 1'b0;
          port_pull_down[gi] <= 1'b0;
        end else if (!active[gi]) begin
          port_out[gi]       <= 1'b0;
          port_oe[gi]        <= 1'b0;
          port_pull_up[gi]   <= 1'b0;
          port_pull_down[gi] <= 1'b0;
        end else if (!dir_q[gi]) begin
          port_out[gi]       <= 1'b0;
          port_oe[gi]        <= 1'b0;
          port_pull_up[gi]   <= (cfg == CFG_PULL_UP);
          port_pull_down[gi] <= (cfg == CFG_PULL_DOWN);
        end else begin
          port_pull_up[gi]   <= 1'b0;
          port_pull_down[gi] <= 1'b0;
          if (cfg == CFG_HIGH_SIDE) begin
            port_out[gi] <= 1'b1;
            port_oe[gi]  <= level_q[gi];
          end else if (cfg == CFG_LOW_SIDE) begin
            port_out[gi] <= 1'b0;
            port_oe[gi]  <= ~level_q[gi];
          end else begin
            port_out[gi] <= level_q[gi];
            port_oe[gi]  <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // --------------------------------------------------------------------------
  // range check
  // --------------------------------------------------------------------------
  logic [CHANS-1:0]  fault_now;
  logic [DATA_W-1:0] up_lim, lo_lim, sample;
  assign up_lim = {upper_data_limit, LIMIT_SHIFT'(0)};
  assign lo_lim = {lower_data_limit, LIMIT_SHIFT'(0)};
  always_comb begin
    sample    = '0;
    fault_now = '0;
    for (int c = 0; c < CHANS; c++) begin
      sample       = chan_data[c*DATA_W +: DATA_W];
      fault_now[c] = (sample > up_lim) || (sample < lo_lim);
    end
  end

  logic [CHANS-1:0] range_fault_q;
  logic             autocfg_fail_q, recfg_fail_q;
  always_ff @(posedge clock) begin
    if (blk_rst) begin
      range_fault_q  <= '0;
      autocfg_fail_q <= 1'b0;
      recfg_fail_q   <= 1'b0;
    end else if (check_stb && autocfg_en) begin
      range_fault_q <= fault_now;
      if (check_reconfig) recfg_fail_q <= |fault_now;
      else autocfg_fail_q <= |fault_now;
    end
  end

  // --------------------------------------------------------------------------
  // read mux
  // --------------------------------------------------------------------------
  logic [PORTS-1:0] data_view;
  logic [7:0]       rd_mux, status_hi;
  assign data_view = (active & ~dir_q & in_lat_q)
                   | (~(active & ~dir_q) & data_q);
  always_comb begin
    status_hi = READ_ZERO;
    status_hi[AUTOCFG_FAIL_BIT] = autocfg_fail_q;
    status_hi[RECFG_FAIL_BIT]   = recfg_fail_q;
    status_hi[CHANS-LOW_STATUS_CHANS-1:0] = range_fault_q[CHANS-1:LOW_STATUS_CHANS];
  end
  always_comb begin
    if (bus.addr == REG_RANGE_FAULT_LOW)        rd_mux = range_fault_q[LOW_STATUS_CHANS-1:0];
    else if (bus.addr == REG_RANGE_FAULT_HIGH)  rd_mux = status_hi;
    else if (bus.addr == REG_PORT_CONFIG_A)     rd_mux = 8'(cfg_a_q);
    else if (bus.addr == REG_PORT_CONFIG_B)     rd_mux = 8'(cfg_b_q);
    else if (bus.addr == REG_PORT_LEVEL_DATA)   rd_mux = 8'(data_view);
    else if (bus.addr == REG_PORT_DIRECTION)    rd_mux = 8'(dir_q);
    else if (bus.addr == REG_PORT_ENABLE)       rd_mux = 8'(en_q);
    else if (bus.addr == REG_PORT_LEVEL_SET ||
             bus.addr == REG_PORT_LEVEL_CLEAR ||
             bus.addr == REG_PORT_LEVEL_TOG)    rd_mux = 8'(data_q);
    else                                        rd_mux = READ_ZERO;
  end
  assign bus.rdata = rd_mux;

endmodule : tgp_port_top

//--- tgp_port_top_props.sv
`timescale 1ns/10ps
module tgp_port_top_props
  import tgp_pkg::*;
#(
  parameter int PORTS = NUM_PORTS,
  parameter int CHANS = NUM_CHANS
) (
  input wire logic             clock,
  input wire logic             sys_rst,
  input wire logic             scl_in,
  input wire logic             sda_out,
  input wire logic             sda_oe,
  input wire logic [PORTS-1:0] electrode_mask,
  input wire logic             charging,
  input wire logic             conv_done,
  input wire logic [PORTS-1:0] port_out,
  input wire logic [PORTS-1:0] port_oe,
  input wire logic [PORTS-1:0] port_pull_up,
  input wire logic [PORTS-1:0] port_pull_down,
  input wire logic             soft_reset_out
);
  // --------
  // idle serial clock count
  // --------
  logic [7:0] scl_high_q;
  always_ff @(posedge clock) begin
    if (sys_rst || !scl_in)
      scl_high_q <= 8'h00;
    else if (scl_high_q != 8'hFF)
      scl_high_q <= scl_high_q + 8'h01;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  sda_never_high_a: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  reset_pins_off_a: assert property (disable iff (1'b0)
    sys_rst |=> {port_oe, port_pull_up, port_pull_down, sda_oe} == '0)
    else $error("pins active after reset");
  one_pull_only_a: assert property (
    (port_pull_up & port_pull_down) == '0) else $error("both pulls on");
  drive_no_pull_a: assert property (
    (port_oe & (port_pull_up | port_pull_down)) == '0) else $error("pull on driven pin");
  electrode_wins_a: assert property (
    (|electrode_mask) [*3] |-> ((port_oe | port_pull_up | port_pull_down) & electrode_mask) == '0)
    else $error("electrode pin still used as port");
  soft_reset_clear_a: assert property (
    soft_reset_out |=> !soft_reset_out && {port_oe, port_pull_up, port_pull_down} == '0)
    else $error("soft reset left pins active");
  ack_scl_low_a: assert property (
    sda_oe != $past(sda_oe) |-> !scl_in) else $error("data line moved while clock high");
  idle_release_a: assert property (scl_high_q >= 8'h28 |-> !sda_oe)
    else $error("data line held while bus idle");
  level_held_a: assert property (
    (charging && !conv_done) [*3] |=> port_out == $past(port_out))
    else $error("output level changed while charging");
endmodule : tgp_port_top_props

bind tgp_port_top tgp_port_top_props #(.PORTS(PORTS), .CHANS(CHANS)) u_props (.*);

//--- tgp_port_top_test.sv
`timescale 1ns/10ps
module tgp_port_top_test;
  import tgp_pkg::*;
  // --------
  // design, bus master and checks
  // --------
  logic         clock, sys_rst, scl, sda_low, sda_oe, sda_out, charging, conv_done;
  logic         check_stb, check_reconfig, autocfg_en, soft_reset_out;
  logic [7:0]   electrode_mask, port_in, port_out, port_oe, pull_up, pull_down;
  logic [129:0] chan_data;
  logic [1:0]   addr_strap;
  int           miscompares, samples_checked, soft_pulses;
  wire          sda_line = !(sda_low || sda_oe);
  tgp_port_top dut (.clock(clock), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_strap(addr_strap), .run_mode(1'b1),
    .electrode_mask(electrode_mask), .charging(charging), .conv_done(conv_done),
    .check_stb(check_stb), .check_reconfig(check_reconfig), .autocfg_en(autocfg_en),
    .upper_data_limit(8'h80), .lower_data_limit(8'h40), .chan_data(chan_data),
    .port_in(port_in), .port_out(port_out), .port_oe(port_oe), .port_pull_up(pull_up),
    .port_pull_down(pull_down), .soft_reset_out(soft_reset_out));
  tgp_master_model mst (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
  always @(posedge clock) begin
    if (soft_reset_out === 1'b1) soft_pulses++;
  end
  initial begin
    clock = 1'b0;
    forever #2.5 clock = !clock;
  end
  task automatic report_and_stop();
    if (miscompares == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] r, input logic [39:0] d, input int n);
    logic ok;
    mst.wr(r, d, n, ok);
    chk({7'h0, ok}, 8'h01);
  endtask : wr
  task automatic rdc(input logic [7:0] r, input logic [7:0] exp);
    logic ok;
    logic [7:0] v;
    mst.rd(r, v, ok);
    chk({7'h0, ok}, 8'h01);
    chk(v, exp);
  endtask : rdc
  task automatic wait_out(input logic [7:0] exp);
    int k;
    for (k = 0; k < 40 && port_out !== exp; k++)
      @(negedge clock);
    chk(port_out, exp);
    if (k == 40)
      report_and_stop();
  endtask : wait_out
  task automatic range_check(input logic recfg, input logic [12:0] bad);
    for (int c = 0; c < 13; c++)
      chan_data[c*10+:10] = bad[c] ? (c[0] ? 10'h258 : 10'h064) : 10'h12C;
    check_reconfig = recfg;
    check_stb = 1'b1;
    @(negedge clock);
    check_stb = 1'b0;
  endtask : range_check
  task automatic t_reset();
    chk(port_oe | pull_up | pull_down, 8'h00);
    for (int r = 8'h73; r <= 8'h77; r++)
      rdc(r[7:0], 8'h00);
    rdc(8'h50, READ_ZERO);
  endtask : t_reset
  task automatic t_output();
    wr(REG_PORT_CONFIG_A, 40'h0F_3CA5_FFFF, 5);
    chk(port_oe, 8'hF6);
    chk(port_out & 8'hF0, 8'hA0);
    rdc(REG_PORT_LEVEL_DATA, 8'hA5);
    wr(REG_PORT_CONFIG_A, 40'h0000, 2);
    chk(port_oe, 8'hFF);
    wr(REG_PORT_LEVEL_SET, 40'h0A, 1);
    wait_out(8'hAF);
    wr(REG_PORT_LEVEL_CLEAR, 40'h81, 1);
    wait_out(8'h2E);
    wr(REG_PORT_LEVEL_TOG, 40'hF0, 1);
    wait_out(8'hDE);
    for (int r = 8'h78; r <= 8'h7A; r++)
      rdc(r[7:0], 8'hDE);
  endtask : t_output
  task automatic t_charge();
    charging = 1'b1;
    wr(REG_PORT_LEVEL_TOG, 40'hFF, 1);
    repeat (8) @(negedge clock);
    chk(port_out, 8'hDE);
    charging = 1'b0;
    conv_done = 1'b1;
    @(negedge clock);
    conv_done = 1'b0;
    wait_out(8'h21);
    electrode_mask = 8'h0F;
    repeat (3) @(negedge clock);
    chk(port_oe, 8'hF0);
    electrode_mask = 8'h00;
  endtask : t_charge
  task automatic t_input();
    port_in = 8'h3C;
    wr(REG_PORT_CONFIG_A, 40'hF0_C355_00, 4);
    chk(pull_up, 8'hC0);
    chk(pull_down, 8'h30);
    chk(port_oe, 8'h00);
    rdc(REG_PORT_LEVEL_DATA, 8'h3C);
    wr(REG_PORT_DIRECTION, 40'hFF, 1);
    rdc(REG_PORT_LEVEL_DATA, 8'h55);
    wr(REG_PORT_ENABLE, 40'h00, 1);
    chk(port_oe | pull_up | pull_down, 8'h00);
  endtask : t_input
  task automatic t_status();
    autocfg_en = 1'b1;
    range_check(1'b0, 13'h1201);
    rdc(REG_RANGE_FAULT_LOW, 8'h01);
    rdc(REG_RANGE_FAULT_HIGH, 8'h92);
    range_check(1'b1, 13'h0000);
    rdc(REG_RANGE_FAULT_HIGH, 8'h80);
    range_check(1'b1, 13'h0008);
    autocfg_en = 1'b0;
    range_check(1'b0, 13'h00FF);
    wr(REG_RANGE_FAULT_LOW, 40'hFF, 1);
    rdc(REG_RANGE_FAULT_LOW, 8'h08);
    rdc(REG_RANGE_FAULT_HIGH, 8'hC0);
    wr(REG_SOFT_RESET, 40'h12, 1);
    chk(8'(soft_pulses), 8'h00);
    rdc(REG_PORT_DIRECTION, 8'hFF);
    wr(REG_SOFT_RESET, 40'h63, 1);
    chk(8'(soft_pulses), 8'h01);
    rdc(REG_RANGE_FAULT_HIGH, 8'h00);
    rdc(REG_PORT_DIRECTION, 8'h00);
  endtask : t_status
  task automatic t_strap();
    logic ok;
    addr_strap = 2'b11;
    sys_rst = 1'b1;
    repeat (3) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    mst.wr(REG_PORT_ENABLE, 40'hFF, 1, ok);
    chk({7'h0, ok}, 8'h00);
    mst.target_addr = SLAVE_ADDR_SCL;
    rdc(REG_PORT_ENABLE, 8'h00);
  endtask : t_strap
  initial begin
    {sys_rst, charging, conv_done, check_stb, check_reconfig, autocfg_en} = 6'b10_0000;
    {addr_strap, electrode_mask, port_in, chan_data} = '0;
    miscompares = 0;
    samples_checked = 0;
    repeat (6) @(negedge clock);
    sys_rst = 1'b0;
    repeat (4) @(negedge clock);
    t_reset();
    t_output();
    t_charge();
    t_input();
    t_status();
    t_strap();
    report_and_stop();
  end
  initial begin
    repeat (95000) @(posedge clock);
    miscompares++;
    report_and_stop();
  end
endmodule : tgp_port_top_test

//--- tgp_regbus_if.sv
`timescale 1ns/10ps
interface tgp_regbus_if;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport slave_side (output wr_stb, output rd_stb, output addr, output wdata, input rdata);
  modport regs_side  (input wr_stb, input rd_stb, input addr, input wdata, output rdata);
endinterface : tgp_regbus_if
